/* File: shared/hall_ctrl_defines.svh */
// Constants for the Hall-sensor emulating controller.
// Assumes a single 25 MHz clock and the commutation driver outside.
`ifndef HALL_CTRL_DEFINES_SVH
`define HALL_CTRL_DEFINES_SVH
`define CLK_PERIOD_NS 40
`define SECTOR_COUNT 6
`define SECTOR_DEG 60
`define SENSOR_SPACING_DEG 30
`define WINDOW_WIDTH_DEG 90
`define WINDOW_GAP_DEG 180
`define STEP_DIV_RST 16'h0100
`define SECTOR_RST 3'h0
`endif

/* File: shared/hall_ctrl_pkg.sv */
// Types shared by the Hall-sensor emulating controller.
// Assumes nothing beyond the constants header.
package hall_ctrl_pkg;
  typedef struct packed {
    logic chan_a;
    logic chan_b;
    logic chan_c;
  } hall_code_type;
  typedef struct packed {
    logic high_a;
    logic high_b;
    logic high_c;
    logic low_a;
    logic low_b;
    logic low_c;
  } drive_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_type;
endpackage

/* File: logic/hall_commutation_host.sv */
// Controller that drives a three-phase commutation driver from outside.
// Assumes the driver's Hall inputs, disable pin and open-collector speed
// pulse are wired to the ports below; one 25 MHz clock, async reset.
//
// Overview of operation
// - Hall channels change 30 degrees apart.
// - Sensor high under 90-degree windows.
// - Forward: first, second, third channel rise.
// - Mismatched motor sensors remapped to channels.
// - Channel level is sign of difference.
`include "hall_ctrl_defines.svh"

module hall_commutation_host (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic disable_i,
  input wire logic remap_en_i,
  input wire logic [15:0] step_div_i,
  input wire logic motor_sensor_a_i,
  input wire logic motor_sensor_b_i,
  input wire logic motor_sensor_c_i,
  input wire logic speed_pulse_i,
  output logic [2:0] hall_pos_o,
  output logic [2:0] hall_neg_o,
  output logic out_disable_o,
  output logic [5:0] expect_drive_o,
  output logic speed_pulse_o,
  output logic mismatch_o,
  output logic [2:0] sector_o
);

  ////////////////////////////////////////////////////////////////////////
  // Sector sequencer: steps the emulated rotor in 60-degree sectors.

  hall_ctrl_pkg::run_state_type state_q;
  logic [15:0] div_q;
  logic [2:0] sector_q;
  logic step;

  assign step = (state_q == hall_ctrl_pkg::ST_RUN) && (div_q == 16'h0000);

  // Run state follows the run request.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= hall_ctrl_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        hall_ctrl_pkg::ST_IDLE: begin
          if (run_i) begin
            state_q <= hall_ctrl_pkg::ST_RUN;
          end
        end
        hall_ctrl_pkg::ST_RUN: begin
          if (!run_i) begin
            state_q <= hall_ctrl_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Divider gives a one-cycle step enable; a zero divisor still steps
  // every cycle rather than stalling.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q <= `STEP_DIV_RST;
    end else if (state_q != hall_ctrl_pkg::ST_RUN || div_q == 16'h0000) begin
      div_q <= step_div_i;
    end else begin
      div_q <= div_q - 16'h0001;
    end
  end

  // Forward order advances one sector per step and wraps after six.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sector_q <= `SECTOR_RST;
    end else if (step) begin
      sector_q <= (sector_q == 3'h5) ? 3'h0 : sector_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hall code generation for the emulated rotor.

  hall_ctrl_pkg::hall_code_type code;
  hall_ctrl_pkg::drive_type exp_drive;

  // Sector order 100,110,111,011,001,000: one channel moves per step,
  // first channel leads, so only the six legal codes are produced.
  always_comb begin
    code = '0;
    unique case (sector_q)
      3'h0: code = 3'b100;
      3'h1: code = 3'b110;
      3'h2: code = 3'b111;
      3'h3: code = 3'b011;
      3'h4: code = 3'b001;
      3'h5: code = 3'b000;
      default: code = 3'b000;
    endcase
  end

  // Motor sensors either pass straight or use the remapped pattern:
  // third sensor to channel a, inverted first to b, second to c.
  hall_ctrl_pkg::hall_code_type motor_code;
  logic [2:0] sens_meta_q;
  logic [2:0] sens_sync_q;
  logic spd_meta_q;
  logic spd_sync_q;

  // Pin inputs pass two flip-flops before use. The speed line resets low
  // to match channel a, which is low while reset holds, so no false
  // mismatch follows the release of reset.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sens_meta_q <= 3'h0;
      sens_sync_q <= 3'h0;
      spd_meta_q <= 1'b0;
      spd_sync_q <= 1'b0;
    end else begin
      sens_meta_q <= {motor_sensor_a_i, motor_sensor_b_i, motor_sensor_c_i};
      sens_sync_q <= sens_meta_q;
      spd_meta_q <= speed_pulse_i;
      spd_sync_q <= spd_meta_q;
    end
  end

  always_comb begin
    if (remap_en_i) begin
      motor_code = {sens_sync_q[0], ~sens_sync_q[2], sens_sync_q[1]};
    end else begin
      motor_code = sens_sync_q;
    end
  end

  // Channel source: emulated rotor while running, real sensors otherwise.
  hall_ctrl_pkg::hall_code_type chan;
  assign chan = (state_q == hall_ctrl_pkg::ST_RUN) ? code : motor_code;

  // Expected driver pattern, used to check the driver's behaviour.
  always_comb begin
    exp_drive = '0;
    unique case (chan)
      3'b100: exp_drive = 6'b001_100;
      3'b110: exp_drive = 6'b001_010;
      3'b111: exp_drive = 6'b100_010;
      3'b011: exp_drive = 6'b100_001;
      3'b001: exp_drive = 6'b010_001;
      3'b000: exp_drive = 6'b010_100;
      default: exp_drive = 6'b000_000;
    endcase
    if (disable_i) begin
      exp_drive = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered pin drive. Each channel is sent as a differential pair:
  // positive carries the level, negative the reference opposite.

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hall_pos_o <= 3'h0;
      hall_neg_o <= 3'h7;
      out_disable_o <= 1'b1;
      expect_drive_o <= 6'h00;
      sector_o <= 3'h0;
    end else begin
      hall_pos_o <= chan;
      hall_neg_o <= ~chan;
      out_disable_o <= disable_i;
      expect_drive_o <= exp_drive;
      sector_o <= sector_q;
    end
  end

  // Speed pulse check: the driver's output must follow channel a,
  // compared two cycles late to match the input synchroniser.
  // The two-cycle delayed channel a and the synchronised line arrive on the same edge, so a
  // third stage would flag a false one-cycle mismatch at each transition.
  logic [1:0] chan_a_dly_q;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_a_dly_q <= 2'h0;
      speed_pulse_o <= 1'b0;
      mismatch_o <= 1'b0;
    end else begin
      chan_a_dly_q <= {chan_a_dly_q[0], hall_pos_o[2]};
      speed_pulse_o <= spd_sync_q;
      mismatch_o <= (spd_sync_q != chan_a_dly_q[1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_no_shoot_through: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (expect_drive_o[5:3] & expect_drive_o[2:0]) == 3'h0)
    else $error("high and low side expected on one phase");

  a_disable_all_off: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    disable_i |=> expect_drive_o == 6'h00)
    else $error("drive expected while disabled");

  a_one_pair_active: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    expect_drive_o != 6'h00 |->
      $countones(expect_drive_o[5:3]) == 1 &&
      $countones(expect_drive_o[2:0]) == 1)
    else $error("not exactly one high and one low side");

  a_diff_pair: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    hall_neg_o == ~hall_pos_o)
    else $error("differential pair not complementary");

  a_one_chan_step: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    $past(state_q) == hall_ctrl_pkg::ST_RUN &&
      state_q == hall_ctrl_pkg::ST_RUN |->
      $countones(code ^ $past(code)) <= 1)
    else $error("more than one Hall channel changed at once");

  a_legal_code: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    code != 3'b010 && code != 3'b101)
    else $error("illegal Hall code generated");

  a_forward_order: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    step && sector_q == 3'h0 |=> code == 3'b110)
    else $error("second channel did not follow the first");

  a_speed_follows: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    ##1 spd_sync_q == $past(spd_meta_q) |=>
      speed_pulse_o == $past(spd_sync_q))
    else $error("speed pulse not forwarded");

endmodule // hall_commutation_host

/* File: tb/hall_driver_model.sv */
// Behavioural model of the commutation driver fed by the controller.
// Assumes differential Hall inputs and a pulled-up speed pulse line.
module hall_driver_model (
  input wire logic [2:0] hall_pos_i,
  input wire logic [2:0] hall_neg_i,
  input wire logic inhibit_i,
  output hall_ctrl_pkg::drive_type drive_o,
  output logic speed_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] chan;
  // A channel is high only when its positive input is above the negative.
  assign chan = hall_pos_i & ~hall_neg_i;
  // Fixed table; the recirculating phase keeps both switches off.
  always_comb begin
    case (chan)
      3'h4: drive_o = 6'h0c;
      3'h6: drive_o = 6'h0a;
      3'h7: drive_o = 6'h22;
      3'h3: drive_o = 6'h21;
      3'h1: drive_o = 6'h11;
      3'h0: drive_o = 6'h14;
      default: drive_o = 6'h00;
    endcase
    if (inhibit_i) begin
      drive_o = 6'h00;
    end
  end
  // Open collector: a released line shows the pull-up level.
  assign speed_pulse_o = chan[2] ? 1'b1 : 1'b0;
endmodule // hall_driver_model

/* File: tb/hall_commutation_decoder_tb.sv */
// Self-checking bench for the Hall-sensor emulating controller.
// Assumes the driver model in hall_driver_model answers the controller.
module hall_commutation_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, run = 1'b0, dis = 1'b0, remap = 1'b0;
  logic fault = 1'b0, sp_m, sp_in, odis, sp_o, mism;
  logic [2:0] sens = 3'h0, pos, neg, sector;
  logic [5:0] exp_drv;
  hall_ctrl_pkg::drive_type drv;
  int fail_count = 0, checked = 0;
  logic [2:0] codes [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};

  // Free-running clock; a broken speed line is forced low on request.
  always #20 clk = ~clk;
  assign sp_in = sp_m & ~fault;

  hall_commutation_host u_hall_commutation_host (
    .ref_clk_i(clk), .nrst_i(nrst), .run_i(run), .disable_i(dis),
    .remap_en_i(remap), .step_div_i(16'h0002),
    .motor_sensor_a_i(sens[2]), .motor_sensor_b_i(sens[1]),
    .motor_sensor_c_i(sens[0]), .speed_pulse_i(sp_in),
    .hall_pos_o(pos), .hall_neg_o(neg), .out_disable_o(odis),
    .expect_drive_o(exp_drv), .speed_pulse_o(sp_o), .mismatch_o(mism),
    .sector_o(sector));
  hall_driver_model u_hall_driver_model (.hall_pos_i(pos),
    .hall_neg_i(neg), .inhibit_i(odis), .drive_o(drv), .speed_pulse_o(sp_m));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [5:0] e,
                     input logic [5:0] g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", what, e, g);
      fail_count++;
    end
  endtask

  // Inputs change 1 ns after the edge so no race with the sampling edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Two full turns plus one step, so the wrap from 5 to 0 is crossed.
  task automatic run_turns();
    int s = 0;
    int n;
    run = 1'b1;
    for (int k = 0; k < 13; k++) begin
      n = 0;
      while (sector === s[2:0] && n < 50) begin
        tick(1);
        n++;
      end
      if (n == 50) begin
        $display("[ERR] sector step expected change seen none");
        fail_count++;
        report_and_stop();
      end
      s = (s + 1) % 6;
      chk("sector", 6'(s), {3'h0, sector});
      tick(1);
      chk("hall code", {3'h0, codes[s]}, {3'h0, pos});
      chk("hall neg", {3'h0, ~codes[s]}, {3'h0, neg});
      chk("drive", drv, exp_drv);
      chk("overlap", 6'h00, {3'h0, exp_drv[5:3] & exp_drv[2:0]});
      chk("mismatch", 6'h00, {5'h00, mism});
    end
  endtask

  // Disable must clear every switch while stepping goes on.
  task automatic disable_check();
    dis = 1'b1;
    tick(2);
    chk("disable", 6'h01, {5'h00, odis});
    chk("drive off", 6'h00, exp_drv);
    chk("model off", 6'h00, drv);
    dis = 1'b0;
  endtask

  // All eight sensor values, plain then remapped, unused codes included.
  task automatic sensor_check();
    logic [2:0] c;
    run = 1'b0;
    for (int r = 0; r < 2; r++) begin
      remap = r[0];
      for (int v = 0; v < 8; v++) begin
        sens = v[2:0];
        c = (r == 1) ? {sens[0], ~sens[2], sens[1]} : sens;
        tick(8);
        chk("sensor code", {3'h0, c}, {3'h0, pos});
        chk("drive", drv, exp_drv);
        chk("speed", {5'h00, c[2]}, {5'h00, sp_o});
      end
    end
  endtask

  // A speed line stuck low while channel a is high must be flagged.
  task automatic fault_check();
    fault = 1'b1;
    tick(8);
    chk("stuck speed", 6'h01, {5'h00, mism});
    fault = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset is held six cycles; outputs must be off while it is held.
  initial begin
    tick(6);
    chk("reset disable", 6'h01, {5'h00, odis});
    chk("reset drive", 6'h00, exp_drv);
    nrst = 1'b1;
    tick(2);
    run_turns();
    disable_check();
    sensor_check();
    fault_check();
    report_and_stop();
  end
endmodule // hall_commutation_decoder_tb
